// ==== common/pic_pkg.sv ====
// Purpose: Shared constants of the priority interrupt unit
// Assumes: 32-bit AHB-Lite register bus, 50 MHz clock
// Notes: Register indices times four give the byte addresses
package pic_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam logic [4:0] NMI_HOLD_CYC = 5'd20;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [31:0] IDX_PORT_FLAGS = 32'h0400_0008;
  localparam logic [31:0] IDX_EXT_FLAGS = 32'h0400_0004;
  localparam logic [31:0] IDX_PERI_FLAGS = 32'h0400_0006;
  localparam logic [31:0] IDX_CTRL_ONE = 32'h0400_0010;
  localparam logic [31:0] IDX_CTRL_TWO = 32'h0400_0012;
  localparam logic [31:0] IDX_PORT_EN = 32'h0400_0014;
  localparam logic [31:0] IDX_PRI_C = 32'h0400_0016;
  localparam logic [31:0] IDX_PRI_D = 32'h0400_0018;
  localparam logic [31:0] IDX_PRI_E = 32'h0400_001a;
  localparam logic [31:0] IDX_NMI_CTRL = 32'hffff_fee0;
  localparam logic [31:0] IDX_PRI_A = 32'hffff_fee2;
  localparam logic [31:0] IDX_PRI_B = 32'hffff_fee4;
  localparam logic [31:0] IDX_STATUS = 32'h0400_0020;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int NMI_LVL_BIT = 15;
  localparam int NMI_EDGE_BIT = 8;
  localparam int CTRL_DIS_BIT = 15;
  localparam int CTRL_BLOCK_MASK_OVERRIDE_BIT_BIT = 13;
  localparam int CTRL_SEL2_BIT = 12;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [1:0] SENSE_FALL = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_LOW = 2'h2;
  localparam logic [1:0] SENSE_HIGH = 2'h3;

  // ----------------------------------------
  // Sources
  // ----------------------------------------
  localparam int NSRC = 22;
  localparam logic [4:0] NMI_LVL = 5'h10;
  localparam logic [3:0] ENC_NONE = 4'hf;

  typedef enum logic [0:0] {
    PIC_BUS_IDLE = 1'b0,
    PIC_BUS_DATA = 1'b1
  } pic_bus_t;
endpackage

// ==== verilog/pic_sync.sv ====
// Purpose: Two-stage synchroniser with edge detection
// Assumes: Inputs asynchronous to clk
// Notes: Edges are taken between second and third stage
`timescale 1ns/1ns
module pic_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign lvl = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

  property p_sync_delay;
    @(posedge clk) disable iff (!rst_n)
    (din[0] ##1 din[0]) |=> lvl[0];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync lag wrong");
endmodule

// ==== verilog/pic_top.sv ====
// Purpose: Priority interrupt unit with AHB-Lite register slave
// Assumes: Pins synchronised here; CPU supplies block bit and mask
// Notes: Every bus transfer takes one wait state
//
// Behaviour
// - Software sets 16 priority levels per external, port and peripheral source
// - Nonmaskable pin level readable in status bit
// - Notify output flags pending work while released
// - Nonmaskable control resets to pin level
// - All registers take reset values on reset
// - Levels 0..16; level 0 never requested
// - Nonmaskable level 16, gated by disable/block
// - Nonmaskable edge polarity from select bit
// - Sleep or standby ignores block bit for nonmaskable only
// - Edge select change blanks detection 20 cycles
// - Taking interrupt leaves CPU mask level alone
// - Block plus override lets nonmaskable through
// - Nonmaskable wakes standby unless disabled
// - Six external inputs, level/edge, priority C/D
// - Edge flag cleared by read 1, write 0
// - External 0..4 wake standby with 32k clock
// - Encoded 0000 is level 15, 1111 none
// - Equal levels served in fixed order
// - Reset clears every priority to zero
`timescale 1ns/1ns
module pic_top
  import pic_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic nmi_pin,
  input wire logic [5:0] external_request_inputs,
  input wire logic [3:0] encoded_level_inputs,
  input wire logic [3:0] second_encoded_level_inputs,
  input wire logic [15:0] port_interrupt_inputs,
  input wire logic [11:0] periph_req,
  input wire logic refresh_req,
  input wire logic bus_released,
  input wire logic cpu_block_bit,
  input wire logic [3:0] cpu_mask_level,
  input wire logic sleep_mode,
  input wire logic standby_mode,
  input wire logic rtc_32k_in_use,
  input wire logic nmi_ack,
  output logic intr_req,
  output logic [4:0] intr_level,
  output logic [4:0] intr_source,
  output logic wake_req,
  output logic bus_request_notify_output
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic nmi_lvl, nmi_rise, nmi_fall;
  logic [5:0] irq_lvl, irq_rise, irq_fall;
  logic [15:0] pint_lvl;
  logic [7:0] enc_lvl;

  pic_sync #(.W(1)) u_nmi_sync (
    .clk(clk), .rst_n(rst_n), .din(nmi_pin),
    .lvl(nmi_lvl), .rise(nmi_rise), .fall(nmi_fall));
  pic_sync #(.W(6)) u_irq_sync (
    .clk(clk), .rst_n(rst_n), .din(external_request_inputs),
    .lvl(irq_lvl), .rise(irq_rise), .fall(irq_fall));
  pic_sync #(.W(16)) u_pint_sync (
    .clk(clk), .rst_n(rst_n), .din(port_interrupt_inputs),
    .lvl(pint_lvl), .rise(), .fall());
  // Encoded lines are synchronised bit by bit on one clock; skew can briefly show a mixed code
  pic_sync #(.W(8)) u_enc_sync (
    .clk(clk), .rst_n(rst_n),
    .din({second_encoded_level_inputs, encoded_level_inputs}),
    .lvl(enc_lvl), .rise(), .fall());

  // ----------------------------------------
  // Bus slave and registers
  // ----------------------------------------
  pic_bus_t bus_q, bus_d;
  logic [29:0] adr_q, adr_d;
  logic wr_q, wr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hreadyout_d;
  logic nonmaskable_edge_select_q, nonmaskable_edge_select_d;
  logic [15:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d, port_interrupt_enables_q, port_interrupt_enables_d;
  logic [15:0] pria_q, pria_d, prib_q, prib_d, pric_q, pric_d;
  logic [15:0] prid_q, prid_d, prie_q, prie_d;
  logic [5:0] external_request_flags_q, external_request_flags_d, armed_q, armed_d;
  logic [4:0] hold_q, hold_d;
  logic nmi_pend_q, nmi_pend_d;
  logic [11:0] peri_q;
  logic [4:0] best_l_q;
  logic [4:0] best_s_q;
  logic acc, nonmaskable_edge_select_chg, wr_external_request_flags, nmi_edge;
  logic [15:0] rd;

  function automatic logic hit(input logic [29:0] a, input logic [31:0] idx);
    hit = (a == idx[29:0]);
  endfunction

  assign acc = hsel && htrans[1] && hready;
  assign wr_external_request_flags = (bus_q == PIC_BUS_DATA) && wr_q && hit(adr_q, IDX_EXT_FLAGS);
  assign nonmaskable_edge_select_chg = (bus_q == PIC_BUS_DATA) && wr_q && hit(adr_q, IDX_NMI_CTRL)
                    && (hwdata[NMI_EDGE_BIT] != nonmaskable_edge_select_q);
  assign nmi_edge = nonmaskable_edge_select_q ? nmi_rise : nmi_fall;

  always_comb begin
    rd = 16'h0000;
    if (hit(adr_q, IDX_NMI_CTRL)) begin
      rd[NMI_LVL_BIT] = nmi_lvl;
      rd[NMI_EDGE_BIT] = nonmaskable_edge_select_q;
    end
    if (hit(adr_q, IDX_CTRL_ONE)) rd = ctl1_q;
    if (hit(adr_q, IDX_CTRL_TWO)) rd = ctl2_q;
    if (hit(adr_q, IDX_PORT_EN)) rd = port_interrupt_enables_q;
    if (hit(adr_q, IDX_PRI_A)) rd = pria_q;
    if (hit(adr_q, IDX_PRI_B)) rd = prib_q;
    if (hit(adr_q, IDX_PRI_C)) rd = pric_q;
    if (hit(adr_q, IDX_PRI_D)) rd = prid_q;
    if (hit(adr_q, IDX_PRI_E)) rd = prie_q;
    if (hit(adr_q, IDX_EXT_FLAGS)) rd = {10'h000, external_request_flags_q};
    if (hit(adr_q, IDX_PERI_FLAGS)) rd = {8'h00, peri_q[7:0]};
    if (hit(adr_q, IDX_PORT_FLAGS)) rd = {14'h0000, |(pint_lvl[15:8] & port_interrupt_enables_q[15:8]),
                                          |(pint_lvl[7:0] & port_interrupt_enables_q[7:0])};
    if (hit(adr_q, IDX_STATUS)) rd = {best_s_q, best_l_q, nmi_pend_q, hold_q};
  end

  always_comb begin
    bus_d = bus_q;
    adr_d = adr_q;
    wr_d = wr_q;
    hrdata_d = hrdata_q;
    hreadyout_d = hreadyout_q;
    nonmaskable_edge_select_d = nonmaskable_edge_select_q;
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    port_interrupt_enables_d = port_interrupt_enables_q;
    pria_d = pria_q;
    prib_d = prib_q;
    pric_d = pric_q;
    prid_d = prid_q;
    prie_d = prie_q;
    armed_d = armed_q;
    case (bus_q)
      PIC_BUS_IDLE: begin
        if (acc) begin
          bus_d = PIC_BUS_DATA;
          adr_d = haddr[31:2];
          wr_d = hwrite;
          hreadyout_d = 1'b0;
        end
      end
      PIC_BUS_DATA: begin
        bus_d = PIC_BUS_IDLE;
        hreadyout_d = 1'b1;
        hrdata_d = 32'h0000_0000;
        if (!wr_q) begin
          hrdata_d = {16'h0000, rd};
          if (hit(adr_q, IDX_EXT_FLAGS)) armed_d = external_request_flags_q;
        end else begin
          if (hit(adr_q, IDX_NMI_CTRL)) nonmaskable_edge_select_d = hwdata[NMI_EDGE_BIT];
          if (hit(adr_q, IDX_CTRL_ONE)) ctl1_d = hwdata[15:0];
          if (hit(adr_q, IDX_CTRL_TWO)) ctl2_d = hwdata[15:0];
          if (hit(adr_q, IDX_PORT_EN)) port_interrupt_enables_d = hwdata[15:0];
          if (hit(adr_q, IDX_PRI_A)) pria_d = hwdata[15:0];
          if (hit(adr_q, IDX_PRI_B)) prib_d = hwdata[15:0];
          if (hit(adr_q, IDX_PRI_C)) pric_d = hwdata[15:0];
          if (hit(adr_q, IDX_PRI_D)) prid_d = hwdata[15:0];
          if (hit(adr_q, IDX_PRI_E)) prie_d = hwdata[15:0];
          if (hit(adr_q, IDX_EXT_FLAGS)) armed_d = 6'h00;
        end
      end
      default: bus_d = PIC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= PIC_BUS_IDLE;
      adr_q <= '0;
      wr_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      nonmaskable_edge_select_q <= 1'b0;
      ctl1_q <= RST_WORD;
      ctl2_q <= RST_WORD;
      port_interrupt_enables_q <= RST_WORD;
      pria_q <= RST_WORD;
      prib_q <= RST_WORD;
      pric_q <= RST_WORD;
      prid_q <= RST_WORD;
      prie_q <= RST_WORD;
      armed_q <= 6'h00;
    end else begin
      bus_q <= bus_d;
      adr_q <= adr_d;
      wr_q <= wr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= hreadyout_d;
      nonmaskable_edge_select_q <= nonmaskable_edge_select_d;
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      port_interrupt_enables_q <= port_interrupt_enables_d;
      pria_q <= pria_d;
      prib_q <= prib_d;
      pric_q <= pric_d;
      prid_q <= prid_d;
      prie_q <= prie_d;
      armed_q <= armed_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  // ----------------------------------------
  // Detection and arbitration
  // ----------------------------------------
  logic [4:0] lv [NSRC];
  logic [4:0] best_l, best_s;
  logic [3:0] enc1, enc2, irl;
  logic [23:0] irq_pri;
  logic [47:0] peri_pri;
  logic nmi_ok, req_d, wake_d, notify_d;
  logic intr_req_q, wake_q, notify_q;
  logic [1:0] sense;

  assign irq_pri = {prid_q[7:0], pric_q};
  assign peri_pri = {prie_q, prib_q, pria_q};
  assign enc1 = ENC_NONE - enc_lvl[3:0];
  assign enc2 = ctl1_q[CTRL_SEL2_BIT] ? ENC_NONE - enc_lvl[7:4] : 4'h0;
  assign irl = (enc2 > enc1) ? enc2 : enc1;
  // Sleep and standby bypass the block bit, not the disable bit
  assign nmi_ok = !ctl1_q[CTRL_DIS_BIT] && (ctl1_q[CTRL_BLOCK_MASK_OVERRIDE_BIT_BIT] || !cpu_block_bit
                  || sleep_mode || standby_mode);

  always_comb begin
    external_request_flags_d = external_request_flags_q;
    hold_d = (hold_q != 5'd0) ? hold_q - 5'd1 : hold_q;
    if (nonmaskable_edge_select_chg) hold_d = NMI_HOLD_CYC;
    nmi_pend_d = nmi_pend_q && !nmi_ack;
    if (nmi_edge && hold_q == 5'd0) nmi_pend_d = 1'b1;
    sense = SENSE_FALL;
    for (int i = 0; i < 6; i++) begin
      sense = ctl1_q[2*i +: 2];
      case (sense)
        SENSE_LOW: external_request_flags_d[i] = ~irq_lvl[i];
        SENSE_HIGH: external_request_flags_d[i] = irq_lvl[i];
        default: begin
          if (wr_external_request_flags && armed_q[i] && !hwdata[i]) external_request_flags_d[i] = 1'b0;
          if (sense == SENSE_RISE ? irq_rise[i] : irq_fall[i]) external_request_flags_d[i] = 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    lv[0] = (nmi_pend_q && nmi_ok) ? NMI_LVL : 5'h00;
    lv[1] = {1'b0, irl};
    for (int i = 0; i < 6; i++) lv[2+i] = external_request_flags_q[i] ? {1'b0, irq_pri[4*i +: 4]} : 5'h00;
    lv[8] = |(pint_lvl[7:0] & port_interrupt_enables_q[7:0]) ? {1'b0, prid_q[15:12]} : 5'h00;
    lv[9] = |(pint_lvl[15:8] & port_interrupt_enables_q[15:8]) ? {1'b0, prid_q[11:8]} : 5'h00;
    for (int k = 0; k < 12; k++) lv[10+k] = peri_q[k] ? {1'b0, peri_pri[4*k +: 4]} : 5'h00;
    best_l = 5'h00;
    best_s = 5'h00;
    for (int s = 0; s < NSRC; s++) begin
      if (lv[s] > best_l) begin
        best_l = lv[s];
        best_s = 5'(s);
      end
    end
    // Mask level is only compared, never written back
    req_d = (best_l == NMI_LVL) ||
            (!cpu_block_bit && best_l > {1'b0, cpu_mask_level});
    wake_d = standby_mode && ((nmi_pend_q && !ctl1_q[CTRL_DIS_BIT]) ||
             (rtc_32k_in_use && (lv[2] > {1'b0, cpu_mask_level} ||
              lv[3] > {1'b0, cpu_mask_level} || lv[4] > {1'b0, cpu_mask_level} ||
              lv[5] > {1'b0, cpu_mask_level} || lv[6] > {1'b0, cpu_mask_level})));
    notify_d = bus_released && (refresh_req || irl != 4'h0 || |external_request_flags_q ||
               |peri_q || nmi_pend_q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      external_request_flags_q <= RST_FLAGS[5:0];
      hold_q <= 5'd0;
      nmi_pend_q <= 1'b0;
      peri_q <= 12'h000;
      best_l_q <= 5'h00;
      best_s_q <= 5'h00;
      intr_req_q <= 1'b0;
      wake_q <= 1'b0;
      notify_q <= 1'b0;
    end else begin
      external_request_flags_q <= external_request_flags_d;
      hold_q <= hold_d;
      nmi_pend_q <= nmi_pend_d;
      peri_q <= periph_req;
      best_l_q <= best_l;
      best_s_q <= best_s;
      intr_req_q <= req_d;
      wake_q <= wake_d;
      notify_q <= notify_d;
    end
  end

  assign intr_req = intr_req_q;
  assign intr_level = best_l_q;
  assign intr_source = best_s_q;
  assign wake_req = wake_q;
  assign bus_request_notify_output = notify_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_no_zero;
    @(posedge clk) disable iff (!rst_n)
    intr_req_q |-> best_l_q != 5'h00;
  endproperty
  a_no_zero: assert property (p_no_zero) else $error("level 0 requested");

  property p_nmi_take;
    @(posedge clk) disable iff (!rst_n)
    (nmi_pend_q && nmi_ok) |=> intr_req_q && best_l_q == 5'h10 && best_s_q == 5'h00;
  endproperty
  a_nmi_take: assert property (p_nmi_take) else $error("nmi not presented");

  property p_hold_load;
    @(posedge clk) disable iff (!rst_n)
    nonmaskable_edge_select_chg |=> hold_q == 5'd20 ##19 hold_q == 5'd1 ##1 hold_q == 5'd0;
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("blank time wrong");

  property p_hold_blank;
    @(posedge clk) disable iff (!rst_n)
    (hold_q != 5'd0 && !nmi_pend_q) |=> !nmi_pend_q;
  endproperty
  a_hold_blank: assert property (p_hold_blank) else $error("nmi seen in blank");

  property p_flag_sticky;
    @(posedge clk) disable iff (!rst_n)
    (external_request_flags_q[0] && !ctl1_q[1] && !wr_external_request_flags) |=> external_request_flags_q[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("edge flag lost");

  property p_above_mask;
    @(posedge clk) disable iff (!rst_n)
    intr_req_q |-> best_l_q > {1'b0, $past(cpu_mask_level)};
  endproperty
  a_above_mask: assert property (p_above_mask) else $error("request under mask");

  property p_notify;
    @(posedge clk) disable iff (!rst_n)
    (bus_released && refresh_req) |=> notify_q ##0 bus_request_notify_output;
  endproperty
  a_notify: assert property (p_notify) else $error("notify missing");

  property p_nmi_wake;
    @(posedge clk) disable iff (!rst_n)
    (standby_mode && nmi_pend_q && !ctl1_q[CTRL_DIS_BIT]) |=> wake_q;
  endproperty
  a_nmi_wake: assert property (p_nmi_wake) else $error("no nmi wake");

  property p_bus_wait;
    @(posedge clk) disable iff (!rst_n)
    (acc && bus_q == PIC_BUS_IDLE) |=> !hreadyout_q ##1 hreadyout_q;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus timing wrong");
endmodule

// ==== tb/pic_cpu_model.sv ====
// Purpose: Stand-in for the CPU core and the external request sources
// Assumes: Core takes the nonmaskable request after ack_delay cycles
// Notes: Pulses stand four cycles so edge sensing always sees them
`timescale 1ns/1ns
module pic_cpu_model
  import pic_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic intr_req,
  input wire logic [4:0] intr_source,
  input wire logic [4:0] ack_delay,
  input wire logic [5:0] ext_level,
  input wire logic [5:0] ext_fire,
  output logic nmi_ack,
  output logic [5:0] ext_pins
);
  // --------
  // Core acknowledge and pulse stretcher
  // --------
  logic [4:0] wait_q, wait_d;
  logic [5:0] fire_q, fire_d;
  logic [1:0] len_q, len_d;
  logic ack_q, ack_d;

  always_comb begin
    wait_d = (intr_req && intr_source == 5'h00) ? wait_q + 5'h01 : 5'h00;
    ack_d = intr_req && intr_source == 5'h00 && wait_q == ack_delay;
    fire_d = fire_q;
    len_d = len_q;
    if (ext_fire != 6'h00) begin
      fire_d = ext_fire;
      len_d = 2'h3;
    end else if (len_q != 2'h0) begin
      len_d = len_q - 2'h1;
    end else begin
      fire_d = 6'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 5'h00;
      fire_q <= 6'h00;
      len_q <= 2'h0;
      ack_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      fire_q <= fire_d;
      len_q <= len_d;
      ack_q <= ack_d;
    end
  end

  assign nmi_ack = ack_q;
  assign ext_pins = ext_level ^ fire_q;
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the priority interrupt unit
// Assumes: One wait state per transfer; outputs settle within 8 cycles
// Notes: Register index times four is the bus byte address
`timescale 1ns/1ns
module testbench
  import pic_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic nmi_pin = 1'b1;
  logic [3:0] enc = 4'hf;
  logic [11:0] periph = 12'h000;
  logic refresh_req = 1'b0;
  logic bus_released = 1'b0;
  logic block = 1'b0;
  logic [3:0] mask = 4'h0;
  logic sleep = 1'b0;
  logic standby = 1'b0;
  logic rtc = 1'b0;
  logic [4:0] ack_dly = 5'd15;
  logic [5:0] ext_level = 6'h00;
  logic [5:0] ext_fire = 6'h00;
  logic hready, hreadyout, hresp, nmi_ack, intr_req, wake_req, notify;
  logic [31:0] hrdata;
  logic [4:0] intr_level, intr_source;
  logic [5:0] ext_pins;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] regs [12] = '{IDX_PORT_FLAGS, IDX_EXT_FLAGS, IDX_PERI_FLAGS, IDX_CTRL_ONE,
    IDX_CTRL_TWO, IDX_PORT_EN, IDX_PRI_C, IDX_PRI_D, IDX_PRI_E, IDX_NMI_CTRL, IDX_PRI_A,
    IDX_PRI_B};

  always #10 clk = ~clk;
  assign hready = hreadyout;

  pic_top uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nmi_pin(nmi_pin),
    .external_request_inputs(ext_pins), .encoded_level_inputs(enc),
    .second_encoded_level_inputs(4'hf), .port_interrupt_inputs(16'h0000),
    .periph_req(periph), .refresh_req(refresh_req), .bus_released(bus_released),
    .cpu_block_bit(block), .cpu_mask_level(mask), .sleep_mode(sleep),
    .standby_mode(standby), .rtc_32k_in_use(rtc), .nmi_ack(nmi_ack), .intr_req(intr_req),
    .intr_level(intr_level), .intr_source(intr_source), .wake_req(wake_req),
    .bus_request_notify_output(notify));

  pic_cpu_model cpu (.clk(clk), .rst_n(rst_n), .intr_req(intr_req),
    .intr_source(intr_source), .ack_delay(ack_dly), .ext_level(ext_level),
    .ext_fire(ext_fire), .nmi_ack(nmi_ack), .ext_pins(ext_pins));

  // --------
  // Bus and compare helpers
  // --------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic chk_irq(input logic r, input logic [4:0] lvl, input logic [4:0] src);
    if (r) begin
      chk({21'h0, r, lvl, src}, {21'h0, intr_req, intr_level, intr_source});
    end else begin
      chk(32'h0, {31'h0, intr_req});
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= idx << 2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rdc(input logic [31:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk(exp, r);
    chk(32'h0, {31'h0, hresp});
  endtask

  task automatic nmi_edge(input logic v, input logic r, input logic w);
    nmi_pin <= v;
    cyc(8);
    chk_irq(r, NMI_LVL, 5'h00);
    chk({31'h0, w}, {31'h0, wake_req});
    cyc(30);
  endtask

  // Quiet falling step lets any stale request be taken first
  task automatic nmi_rise(input logic r, input logic w);
    nmi_pin <= 1'b0;
    cyc(30);
    nmi_edge(1'b1, r, w);
  endtask

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    n_errors++;
    wrap_up();
  end

  // --------
  // Scenarios
  // --------
  initial begin
    logic [31:0] rd;
    cyc(16);
    rst_n <= 1'b1;
    cyc(3);
    for (int i = 0; i < 12; i++) begin
      rdc(regs[i], (i == 9) ? 32'h8000 : 32'h0);
    end
    for (int i = 3; i < 12; i++) begin
      if (i != 9) begin
        wr(regs[i], 32'hffff_ffff);
        rdc(regs[i], 32'h0000_ffff);
        wr(regs[i], 32'h0);
      end
    end
    wr(IDX_PERI_FLAGS, 32'hffff_ffff);
    rdc(IDX_PERI_FLAGS, 32'h0);
    rdc(32'h0400_0030, 32'h0);
    mask <= 4'hf;
    wr(IDX_CTRL_ONE, 32'h000d);
    wr(IDX_PRI_C, 32'h0005);
    bus(1'b0, IDX_EXT_FLAGS, 32'h0, rd);
    wr(IDX_EXT_FLAGS, 32'h0);
    mask <= 4'h4;
    ext_level <= 6'h02;
    cyc(8);
    chk_irq(1'b0, 5'h00, 5'h00);
    ext_fire <= 6'h01;
    cyc(1);
    ext_fire <= 6'h00;
    cyc(8);
    chk_irq(1'b1, 5'h05, 5'h02);
    mask <= 4'h5;
    cyc(3);
    chk_irq(1'b0, 5'h00, 5'h00);
    standby <= 1'b1;
    rtc <= 1'b1;
    mask <= 4'h4;
    cyc(3);
    chk(32'h1, {31'h0, wake_req});
    rtc <= 1'b0;
    cyc(3);
    chk(32'h0, {31'h0, wake_req});
    standby <= 1'b0;
    wr(IDX_EXT_FLAGS, 32'h0);
    rdc(IDX_EXT_FLAGS, 32'h3);
    wr(IDX_EXT_FLAGS, 32'h0);
    rdc(IDX_EXT_FLAGS, 32'h2);
    ext_level <= 6'h00;
    mask <= 4'h0;
    wr(IDX_PRI_A, 32'h0033);
    periph <= 12'h003;
    cyc(8);
    chk_irq(1'b1, 5'h03, 5'h0a);
    enc <= 4'h0;
    cyc(8);
    chk_irq(1'b1, 5'h0f, 5'h01);
    enc <= 4'he;
    cyc(8);
    chk_irq(1'b1, 5'h03, 5'h0a);
    enc <= 4'hf;
    periph <= 12'h000;
    refresh_req <= 1'b1;
    bus_released <= 1'b1;
    cyc(3);
    chk(32'h1, {31'h0, notify});
    bus_released <= 1'b0;
    cyc(3);
    chk(32'h0, {31'h0, notify});
    refresh_req <= 1'b0;
    nmi_edge(1'b0, 1'b1, 1'b0);
    rdc(IDX_NMI_CTRL, 32'h0);
    nmi_edge(1'b1, 1'b0, 1'b0);
    nmi_edge(1'b0, 1'b1, 1'b0);
    wr(IDX_NMI_CTRL, 32'h0100);
    nmi_edge(1'b1, 1'b0, 1'b0);
    rdc(IDX_NMI_CTRL, 32'h8100);
    nmi_edge(1'b0, 1'b0, 1'b0);
    nmi_edge(1'b1, 1'b1, 1'b0);
    wr(IDX_CTRL_ONE, 32'h8000);
    standby <= 1'b1;
    nmi_rise(1'b0, 1'b0);
    standby <= 1'b0;
    block <= 1'b1;
    wr(IDX_CTRL_ONE, 32'h0);
    nmi_rise(1'b0, 1'b0);
    wr(IDX_CTRL_ONE, 32'h2000);
    nmi_rise(1'b1, 1'b0);
    wr(IDX_CTRL_ONE, 32'h0);
    sleep <= 1'b1;
    nmi_rise(1'b1, 1'b0);
    sleep <= 1'b0;
    block <= 1'b0;
    standby <= 1'b1;
    nmi_rise(1'b1, 1'b1);
    standby <= 1'b0;
    nmi_pin <= 1'b0;
    wr(IDX_PRI_B, 32'h0707);
    rst_n <= 1'b0;
    cyc(16);
    rst_n <= 1'b1;
    cyc(3);
    rdc(IDX_NMI_CTRL, 32'h0);
    rdc(IDX_PRI_B, 32'h0);
    wrap_up();
  end
endmodule
